// ===== rtl/spirs_pkg.sv
// package: register map, field layout, reset values and rate table of the serial rate/status block
`default_nettype none
package spirs_pkg;

  // register offsets on the plain register port
  localparam logic [5:0] SPIRS_CTRL_ADDR = 6'h0D;  // serial_control_register
  localparam logic [5:0] SPIRS_STAT_ADDR = 6'h0E;  // serial_status_register
  localparam logic [5:0] SPIRS_DATA_ADDR = 6'h0F;  // serial_data_register
  localparam logic [5:0] SPIRS_EVST_ADDR = 6'h10;  // sticky event status, read only
  localparam logic [5:0] SPIRS_EVCLR_ADDR = 6'h11; // event clear, write only
  localparam logic [5:0] SPIRS_EVEN_ADDR = 6'h12;  // event enable

  // control register fields
  localparam int CTRL_IRQ_EN = 7;  // serial_irq_enable
  localparam int CTRL_ENABLE = 6;  // interface on
  localparam int CTRL_SS_IN = 5;   // select pin used as input in master mode
  localparam int CTRL_MASTER = 4;  // 1 master, 0 slave
  localparam int CTRL_RATE_HI = 1; // rate_select_high
  localparam int CTRL_RATE_LO = 0; // rate_select_low

  // status register fields
  localparam int STAT_DONE = 7; // transfer_done_flag
  localparam int STAT_WRITE_COLLISION_FLAG = 6; // write_collision_flag
  localparam int STAT_DBL = 0;  // double_speed

  // event status / clear / enable fields
  localparam int EV_DONE = 0;
  localparam int EV_WRITE_COLLISION_FLAG = 1;

  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] STAT_RESET = 8'h00;
  localparam logic [1:0] EV_RESET = 2'h0;

  // clock divisors per rate code, speed doubling off
  localparam logic [7:0] DIV_R0 = 8'h04;
  localparam logic [7:0] DIV_R1 = 8'h10;
  localparam logic [7:0] DIV_R2 = 8'h40;
  localparam logic [7:0] DIV_R3 = 8'h80;
  localparam logic [7:0] ONE8 = 8'h01;

  // cycles per serial clock phase, minus one
  function automatic logic [6:0] spirs_half_m1(input logic dbl, input logic [1:0] rate);
    logic [7:0] div;
    case (rate)
      2'h0: div = DIV_R0;
      2'h1: div = DIV_R1;
      2'h2: div = DIV_R2;
      default: div = DIV_R3;
    endcase
    // doubling halves the divisor, so the phase is a quarter of it
    spirs_half_m1 = dbl ? 7'((div >> 2) - ONE8) : 7'((div >> 1) - ONE8);
  endfunction

  // engine states
  typedef enum logic [1:0] {
    SPIRS_IDLE = 2'h0,
    SPIRS_XFER = 2'h1
  } spirs_st_t;

endpackage
`default_nettype wire

// ===== rtl/spirs_rate_div.sv
// phase tick generator for the master serial clock
`timescale 1ns/10ps
`default_nettype none
module spirs_rate_div #(
  parameter int W = 7
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic run_i,
  input wire logic [W-1:0] half_m1_i,
  output logic tick_o
);

  // counter and tick held together
  typedef struct packed {
    logic [W-1:0] cnt;
    logic tick;
  } spirs_div_state_t;

  spirs_div_state_t s;   // present state
  spirs_div_state_t nxt; // next state

  // count phase cycles; restarting on run keeps every transfer aligned
  always_comb begin
    nxt = s;
    nxt.tick = 1'b0;
    if (!run_i) begin
      nxt.cnt = '0;
    end else if (s.cnt >= half_m1_i) begin
      nxt.cnt = '0;
      nxt.tick = 1'b1;
    end else begin
      nxt.cnt = s.cnt + W'(1);
    end
  end

  // state register
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      s <= '0;
    end else begin
      s <= nxt;
    end
  end

  assign tick_o = s.tick;

endmodule // spirs_rate_div
`default_nettype wire

// ===== rtl/spirs_core.sv
// serial interface rate selection, byte engine and status flags
// Notes on behaviour
// R01 - master clock divide 4/16/64/128, doubled 2/8/32/64
// R02 - rate bits ignored in slave mode
// R03 - external master keeps clock at most quarter rate
// R04 - byte done sets flag, interrupt when enabled
// R05 - master with select input low sets flag
// R06 - vector acknowledge clears done flag
// R07 - status read then data access clears flag
// R08 - data write while busy sets collision flag
// R09 - collision seen then data access clears both
// R10 - status bits five to one read zero
// R11 - doubling bit doubles master clock rate
// R12 - doubled fastest clock period is two cycles
// R13 - clear only after armed read, else unchanged
//
// The strobed register port was decided locally.
`timescale 1ns/10ps
`default_nettype none
module spirs_core
  import spirs_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [5:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic vec_ack_i,
  input wire logic global_irq_en_i,
  output logic irq_o,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_o,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe_o,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe_o,
  input wire logic ss_n_i
);

  // whole block state
  typedef struct packed {
    logic [7:0] ctrl;   // serial_control_register
    logic dbl;          // double_speed
    logic transfer_done_flag;         // transfer_done_flag
    logic write_collision_flag;         // write_collision_flag
    logic arm_f;        // status read saw done flag
    logic arm_w;        // status read saw collision flag
    logic [7:0] tx_sh;  // outgoing shift
    logic [7:0] rx_sh;  // incoming shift
    logic [7:0] rx_buf; // last received byte
    logic [2:0] bits;   // bits finished
    spirs_st_t st;      // engine state
    logic sck;          // master clock level
    logic sck_prev;     // slave clock of last cycle
    logic [1:0] ev_st;  // sticky events
    logic [1:0] ev_en;  // event enables
    logic [7:0] rdata;  // read answer
    logic irq;
    logic sck_oe;
    logic mosi;
    logic mosi_oe;
    logic miso;
    logic miso_oe;
  } spirs_state_t;

  spirs_state_t s;   // present state
  spirs_state_t nxt; // next state

  logic enabled;    // interface on
  logic master;     // on and master
  logic slave_sel;  // on, slave, selected
  logic data_acc;   // any data register access
  logic stat_rd;    // status register read
  logic busy;       // byte in flight
  logic ss_ev;      // select driven low while master
  logic s_rise;     // slave clock rising
  logic s_fall;     // slave clock falling
  logic run;        // master divider running
  logic tick;       // master phase tick
  logic [6:0] half_m1;
  logic done_ev;    // byte completed this cycle
  logic write_collision_flag_ev;    // collision this cycle

  assign enabled = s.ctrl[CTRL_ENABLE];
  assign master = enabled & s.ctrl[CTRL_MASTER];
  assign slave_sel = enabled & ~s.ctrl[CTRL_MASTER] & ~ss_n_i;
  assign data_acc = (rd_i | wr_i) & (addr_i == SPIRS_DATA_ADDR);
  assign stat_rd = rd_i & (addr_i == SPIRS_STAT_ADDR);
  assign busy = (s.st == SPIRS_XFER);
  assign ss_ev = master & s.ctrl[CTRL_SS_IN] & ~ss_n_i; // see R05
  // slave clock is sampled as an ordinary synchronous input
  assign s_rise = slave_sel & ~s.sck_prev & sck_i;
  assign s_fall = slave_sel & s.sck_prev & ~sck_i;
  assign run = master & busy;
  // slave mode never reaches the divider, so the rate bits do nothing there
  assign half_m1 = spirs_half_m1(s.dbl, s.ctrl[CTRL_RATE_HI:CTRL_RATE_LO]); // see R01 see R11 see R02 see R12

  // phase ticks for the master clock
  spirs_rate_div #(
    .W(7)
  ) u_div (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .run_i(run),
    .half_m1_i(half_m1),
    .tick_o(tick)
  );

  // next state: register writes, engine, flags, read answer
  always_comb begin
    nxt = s;
    done_ev = 1'b0;
    write_collision_flag_ev = 1'b0;
    nxt.sck_prev = sck_i;
    // software writes
    if (wr_i) begin
      case (addr_i)
        SPIRS_CTRL_ADDR: nxt.ctrl = wdata_i;
        SPIRS_STAT_ADDR: nxt.dbl = wdata_i[STAT_DBL]; // only writable status bit
        SPIRS_EVEN_ADDR: nxt.ev_en = wdata_i[1:0];
        SPIRS_EVCLR_ADDR: nxt.ev_st = s.ev_st & ~wdata_i[1:0];
        SPIRS_DATA_ADDR: begin
          if (busy) begin
            write_collision_flag_ev = 1'b1; // see R08
          end else begin
            nxt.tx_sh = wdata_i;
            if (master) begin
              // start a master byte, first bit out at once
              nxt.st = SPIRS_XFER;
              nxt.bits = 3'h0;
              nxt.sck = 1'b0;
              nxt.mosi = wdata_i[7];
            end else begin
              nxt.miso = wdata_i[7];
            end
          end
        end
        default: begin
          // unmapped or read-only: ignored
        end
      endcase
    end
    // armed clear on the data access that follows a status read
    if (data_acc) begin
      if (s.arm_w) begin
        nxt.write_collision_flag = 1'b0; // see R09
        nxt.transfer_done_flag = 1'b0; // see R09
      end
      if (s.arm_f) begin
        nxt.transfer_done_flag = 1'b0; // see R07 see R13
      end
      nxt.arm_f = 1'b0;
      nxt.arm_w = 1'b0;
    end
    // a status read remembers what it saw
    if (stat_rd) begin
      nxt.arm_f = s.transfer_done_flag; // see R13
      nxt.arm_w = s.write_collision_flag; // see R13
    end
    // interrupt vector taken
    if (vec_ack_i) begin
      nxt.transfer_done_flag = 1'b0; // see R06
    end
    // master engine, one phase per tick
    if (run && tick) begin
      if (!s.sck) begin
        // rising edge: sample input
        nxt.sck = 1'b1;
        nxt.rx_sh = {s.rx_sh[6:0], miso_i};
      end else begin
        // falling edge: next bit out
        nxt.sck = 1'b0;
        nxt.tx_sh = {s.tx_sh[6:0], 1'b0};
        nxt.mosi = s.tx_sh[6];
        nxt.bits = s.bits + 3'h1;
        if (s.bits == 3'h7) begin
          done_ev = 1'b1; // see R04
          nxt.st = SPIRS_IDLE;
          nxt.rx_buf = s.rx_sh;
        end
      end
    end
    // slave engine follows the external clock
    if (!master) begin
      if (!slave_sel) begin
        // deselect aborts a partial byte
        nxt.st = SPIRS_IDLE;
        nxt.bits = 3'h0;
      end else if (s_rise) begin
        nxt.st = SPIRS_XFER;
        nxt.rx_sh = {s.rx_sh[6:0], mosi_i};
      end else if (s_fall && busy) begin
        nxt.tx_sh = {s.tx_sh[6:0], 1'b0};
        nxt.miso = s.tx_sh[6];
        nxt.bits = s.bits + 3'h1;
        if (s.bits == 3'h7) begin
          done_ev = 1'b1; // see R04 see R02
          nxt.st = SPIRS_IDLE;
          nxt.rx_buf = s.rx_sh;
        end
      end
    end
    // select pulled low under a master: give up the byte
    if (ss_ev || !enabled) begin
      nxt.st = SPIRS_IDLE;
      nxt.sck = 1'b0;
      nxt.bits = 3'h0;
    end
    // hardware sets win over every clear above
    if (done_ev || ss_ev) begin
      nxt.transfer_done_flag = 1'b1; // see R04 see R05
      nxt.ev_st[EV_DONE] = 1'b1;
    end
    if (write_collision_flag_ev) begin
      nxt.write_collision_flag = 1'b1; // see R08
      nxt.ev_st[EV_WRITE_COLLISION_FLAG] = 1'b1;
    end
    // read answer, valid in the next cycle only
    nxt.rdata = 8'h00;
    if (rd_i) begin
      case (addr_i)
        SPIRS_CTRL_ADDR: nxt.rdata = s.ctrl;
        SPIRS_STAT_ADDR: nxt.rdata = {s.transfer_done_flag, s.write_collision_flag, 5'h00, s.dbl}; // see R10
        SPIRS_DATA_ADDR: nxt.rdata = s.rx_buf;
        SPIRS_EVST_ADDR: nxt.rdata = {6'h00, s.ev_st};
        SPIRS_EVEN_ADDR: nxt.rdata = {6'h00, s.ev_en};
        default: nxt.rdata = 8'h00; // unmapped reads zero
      endcase
    end
    // pin drivers
    nxt.sck_oe = nxt.ctrl[CTRL_ENABLE] & nxt.ctrl[CTRL_MASTER];
    nxt.mosi_oe = nxt.sck_oe;
    nxt.miso_oe = nxt.ctrl[CTRL_ENABLE] & ~nxt.ctrl[CTRL_MASTER] & ~ss_n_i;
    // level interrupt: done flag path plus enabled sticky events
    nxt.irq = global_irq_en_i & ((nxt.ctrl[CTRL_IRQ_EN] & nxt.transfer_done_flag) | (|(nxt.ev_st & nxt.ev_en))); // see R04
  end

  // state register; reset values are all zero
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      s <= '0;
    end else begin
      s <= nxt;
    end
  end

  // outputs straight from the state register
  assign rdata_o = s.rdata;
  assign irq_o = s.irq;
  assign sck_o = s.sck;
  assign sck_oe_o = s.sck_oe;
  assign mosi_o = s.mosi;
  assign mosi_oe_o = s.mosi_oe;
  assign miso_o = s.miso;
  assign miso_oe_o = s.miso_oe;

  // helper for the rate check: cycles since the last tick
  logic [7:0] tick_gap;
  logic had_tick;
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      tick_gap <= 8'h00;
      had_tick <= 1'b0;
    end else begin
      tick_gap <= tick ? 8'h01 : ((tick_gap == 8'hFF) ? tick_gap : tick_gap + 8'h01);
      had_tick <= run & (had_tick | tick);
    end
  end

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);

  // phase length follows rate code and doubling
  property p_rate;
    (run && tick && had_tick) |-> (tick_gap == ({1'b0, half_m1} + 8'h01));
  endproperty
  a_rate: assert property (p_rate) else $error("master clock phase length wrong"); // see R01 see R11

  // doubled fastest rate toggles every cycle
  property p_fast;
    (run && s.dbl && s.ctrl[1:0] == 2'h0 && $rose(s.sck)) |=> $fell(s.sck);
  endproperty
  a_fast: assert property (p_fast) else $error("fastest clock not two cycles"); // see R12

  // slave byte ends on eighth falling edge whatever the rate bits
  property p_slave_done;
    (!master && s_fall && busy && s.bits == 3'h7) |=> (s.transfer_done_flag && s.ev_st[EV_DONE] && !busy);
  endproperty
  a_slave_done: assert property (p_slave_done) else $error("slave byte did not finish"); // see R02

  // master byte end sets the done flag
  property p_master_done;
    (run && tick && s.sck && s.bits == 3'h7) |=> (s.transfer_done_flag && !busy && !s.sck);
  endproperty
  a_master_done: assert property (p_master_done) else $error("master byte did not set flag"); // see R04

  // interrupt follows flag and both enables
  property p_irq;
    ($past(global_irq_en_i) && s.transfer_done_flag && s.ctrl[CTRL_IRQ_EN]) |-> irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing"); // see R04

  // select low under master sets flag and stops
  property p_ss;
    ss_ev |=> (s.transfer_done_flag && !busy);
  endproperty
  a_ss: assert property (p_ss) else $error("select low not flagged"); // see R05

  // vector acknowledge clears the flag
  property p_vec;
    (vec_ack_i && !done_ev && !ss_ev) |=> !s.transfer_done_flag;
  endproperty
  a_vec: assert property (p_vec) else $error("vector did not clear flag"); // see R06

  // armed data access clears the flag
  property p_arm_clr;
    (stat_rd && s.transfer_done_flag) ##1 (!stat_rd && !data_acc) ##1 (data_acc && !done_ev && !ss_ev) |=> !s.transfer_done_flag;
  endproperty
  a_arm_clr: assert property (p_arm_clr) else $error("armed access did not clear flag"); // see R07

  // unarmed data access leaves the flag
  property p_no_arm;
    (data_acc && !s.arm_f && !s.arm_w && s.transfer_done_flag && !vec_ack_i) |=> s.transfer_done_flag;
  endproperty
  a_no_arm: assert property (p_no_arm) else $error("unarmed access cleared flag"); // see R13

  // write during a byte flags a collision
  property p_write_collision_flag;
    (wr_i && addr_i == SPIRS_DATA_ADDR && busy) |=> (s.write_collision_flag && s.ev_st[EV_WRITE_COLLISION_FLAG]);
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision not flagged"); // see R08

  // collision seen then data access clears both flags
  property p_write_collision_flag_clr;
    (data_acc && s.arm_w && !write_collision_flag_ev && !done_ev && !ss_ev) |=> (!s.write_collision_flag && !s.transfer_done_flag);
  endproperty
  a_write_collision_flag_clr: assert property (p_write_collision_flag_clr) else $error("collision clear failed"); // see R09

  // reserved status bits read zero, flag bit is live
  property p_rsvd;
    stat_rd |=> (rdata_o[5:1] == 5'h00 && rdata_o[7] == $past(s.transfer_done_flag));
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("status read wrong"); // see R10

  // main scenarios
  c_master: cover property (run && tick && s.sck && s.bits == 3'h7);
  c_slave: cover property (!master && s_fall && busy && s.bits == 3'h7);
  c_collide: cover property (wr_i && addr_i == SPIRS_DATA_ADDR && busy);
  c_clear: cover property ((stat_rd && s.transfer_done_flag) ##2 data_acc);

endmodule // spirs_core
`default_nettype wire

// ===== tb/spirs_peer.sv
// behavioural far-side serial device answering the block in master mode
`timescale 1ns/10ps
`default_nettype none
module spirs_peer (
  input wire logic sck_i,
  input wire logic mosi_i,
  output logic miso_o
);
  logic [7:0] tx_ff; // byte shifted out, msb first
  logic [7:0] rx_ff; // byte captured from the block

  initial begin
    tx_ff = 8'h00;
    rx_ff = 8'h00;
  end

  // preload the answer before the block starts a byte
  task load(input logic [7:0] b);
    tx_ff = b;
  endtask

  // sample on rising clock, as the block expects
  always @(posedge sck_i) begin
    rx_ff <= {rx_ff[6:0], mosi_i};
  end

  // shift on falling clock; refill with inverted bits so a stale line never looks valid
  always @(negedge sck_i) begin
    tx_ff <= {tx_ff[6:0], ~tx_ff[7]};
  end

  assign miso_o = tx_ff[7];
endmodule // spirs_peer
`default_nettype wire

// ===== tb/spi_rate_and_status_tb.sv
// self-checking bench for the serial rate and status block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin bad_count++; \
  $display("[ERR] %s expected %h seen %h", nm, exp, got); end end
module spi_rate_and_status_tb;
  import spirs_pkg::*;
  localparam int LIMIT = 40000; // whole run needs about 4k cycles
  localparam logic [7:0] DIV_T [8] = '{8'h04, 8'h10, 8'h40, 8'h80, 8'h02, 8'h08, 8'h20, 8'h40};
  logic sys_clk_i = 1'b0, reset_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, vec_ack_i = 1'b0, gie = 1'b0;
  logic [5:0] addr_i = 6'h00;
  logic [7:0] wdata_i = 8'h00, rdata_o, rv;
  logic irq_o, sck_o, sck_oe_o, mosi_o, mosi_oe_o, miso_o, miso_oe_o, peer_miso, sck_q;
  logic sck_tb = 1'b0, mosi_tb = 1'b0, ss_n = 1'b1;
  logic [7:0] slv_rx = 8'h00; // bits seen on the slave data output at each rise
  wire logic sck_w, mosi_w, miso_w; // resolved pin levels
  int bad_count = 0, checks_done = 0, cyc = 0, last_r = 0, per = 0;

  assign sck_w = sck_oe_o ? sck_o : sck_tb;
  assign mosi_w = mosi_oe_o ? mosi_o : mosi_tb;
  assign miso_w = miso_oe_o ? miso_o : peer_miso;

  always #50 sys_clk_i = ~sys_clk_i; // 10 MHz

  spirs_core i_dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .vec_ack_i(vec_ack_i), .global_irq_en_i(gie),
    .irq_o(irq_o), .sck_i(sck_w), .sck_o(sck_o), .sck_oe_o(sck_oe_o), .mosi_i(mosi_w),
    .mosi_o(mosi_o), .mosi_oe_o(mosi_oe_o), .miso_i(miso_w), .miso_o(miso_o),
    .miso_oe_o(miso_oe_o), .ss_n_i(ss_n));

  spirs_peer i_peer (.sck_i(sck_w), .mosi_i(mosi_w), .miso_o(peer_miso));

  // cycle counter, serial clock period monitor and hang guard
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    sck_q <= sck_o;
    if (sck_o && !sck_q) begin
      per <= cyc - last_r;
      last_r <= cyc;
    end
    if (cyc == LIMIT) begin
      bad_count++;
      final_report();
    end
  end

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask

  task automatic rd_chk(input string nm, input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    `CHK(nm, exp, d)
  endtask

  // poll the sticky event bit, not the status register, so no clear gets armed
  task automatic wait_done();
    logic [7:0] d;
    d = 8'h00;
    for (int i = 0; i < 600 && d[EV_DONE] !== 1'b1; i++) rd(SPIRS_EVST_ADDR, d);
    `CHK("byte done event", 1'b1, d[EV_DONE])
    wr(SPIRS_EVCLR_ADDR, 8'h03);
  endtask

  task automatic end_test(input string nm);
    $display("test %s finished, mismatches so far %0d", nm, bad_count);
  endtask

  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    // reset values, reserved bits, unmapped place
    rd_chk("control reset", SPIRS_CTRL_ADDR, CTRL_RESET);
    rd_chk("status reset", SPIRS_STAT_ADDR, STAT_RESET);
    wr(SPIRS_STAT_ADDR, 8'hFF);
    rd_chk("status reserved", SPIRS_STAT_ADDR, 8'h01);
    rd_chk("unmapped read", 6'h3F, 8'h00);
    end_test("registers");
    // every rate code with and without doubling
    for (int i = 0; i < 8; i++) begin
      wr(SPIRS_CTRL_ADDR, 8'h50 | 8'(i[1:0]));
      wr(SPIRS_STAT_ADDR, {7'h00, i[2]});
      i_peer.load(8'hA5 ^ 8'(i));
      wr(SPIRS_DATA_ADDR, 8'h3C + 8'(i));
      wait_done();
      `CHK("sck period", DIV_T[i], 8'(per))
      `CHK("mosi byte", 8'h3C + 8'(i), i_peer.rx_ff)
      rd_chk("status done", SPIRS_STAT_ADDR, {7'h40, i[2]});
      rd_chk("miso byte", SPIRS_DATA_ADDR, 8'hA5 ^ 8'(i));
      rd_chk("status cleared", SPIRS_STAT_ADDR, {7'h00, i[2]});
    end
    end_test("rates");
    // write while busy
    wr(SPIRS_STAT_ADDR, 8'h00);
    wr(SPIRS_CTRL_ADDR, 8'h53);
    wr(SPIRS_DATA_ADDR, 8'h11);
    wr(SPIRS_DATA_ADDR, 8'h22);
    rd_chk("collision set", SPIRS_STAT_ADDR, 8'h40);
    rd(SPIRS_DATA_ADDR, rv);
    rd_chk("collision cleared", SPIRS_STAT_ADDR, 8'h00);
    wait_done();
    `CHK("dropped write", 8'h11, i_peer.rx_ff)
    rd_chk("collision byte done", SPIRS_STAT_ADDR, 8'h80);
    rd(SPIRS_DATA_ADDR, rv);
    end_test("collision");
    // data access without prior status read, then vector clear and interrupt
    gie <= 1'b1;
    wr(SPIRS_CTRL_ADDR, 8'hD0);
    wr(SPIRS_DATA_ADDR, 8'h5A);
    @(negedge sys_clk_i);
    `CHK("irq idle", 1'b0, irq_o)
    wait_done();
    @(negedge sys_clk_i);
    `CHK("irq raised", 1'b1, irq_o)
    @(posedge sys_clk_i);
    gie <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    `CHK("irq masked", 1'b0, irq_o)
    @(posedge sys_clk_i);
    gie <= 1'b1;
    rd(SPIRS_DATA_ADDR, rv);
    rd_chk("unarmed access keeps", SPIRS_STAT_ADDR, 8'h80);
    @(posedge sys_clk_i);
    vec_ack_i <= 1'b1;
    @(posedge sys_clk_i);
    vec_ack_i <= 1'b0;
    rd_chk("vector clears", SPIRS_STAT_ADDR, 8'h00);
    @(negedge sys_clk_i);
    `CHK("irq cleared", 1'b0, irq_o)
    end_test("interrupt");
    // select pin pulled low in master mode
    wr(SPIRS_CTRL_ADDR, 8'h70);
    wr(SPIRS_EVEN_ADDR, 8'h01);
    rd_chk("event enable", SPIRS_EVEN_ADDR, 8'h01);
    ss_n <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    ss_n <= 1'b1;
    rd_chk("select low sets", SPIRS_STAT_ADDR, 8'h80);
    rd(SPIRS_DATA_ADDR, rv);
    rd_chk("select event", SPIRS_EVST_ADDR, 8'h01);
    // event path of the interrupt, done flag path masked by the control bit
    @(negedge sys_clk_i);
    `CHK("event irq", 1'b1, irq_o)
    wr(SPIRS_EVCLR_ADDR, 8'h03);
    wr(SPIRS_EVEN_ADDR, 8'h00);
    @(negedge sys_clk_i);
    `CHK("event irq cleared", 1'b0, irq_o)
    end_test("select");
    // slave byte with the slowest rate code set, clocked at an eighth
    wr(SPIRS_CTRL_ADDR, 8'h43);
    wr(SPIRS_DATA_ADDR, 8'hC3);
    ss_n <= 1'b0;
    for (int b = 7; b >= 0; b--) begin
      mosi_tb <= ~b[0]; // pattern 8'h55 msb first
      repeat (4) @(posedge sys_clk_i);
      slv_rx = {slv_rx[6:0], miso_o}; // bit a far master takes on this rise
      sck_tb <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      sck_tb <= 1'b0;
    end
    @(negedge sys_clk_i);
    `CHK("miso drive", 1'b1, miso_oe_o)
    repeat (4) @(posedge sys_clk_i);
    ss_n <= 1'b1;
    wait_done();
    `CHK("slave miso byte", 8'hC3, slv_rx)
    rd_chk("slave status", SPIRS_STAT_ADDR, 8'h80);
    rd_chk("slave byte", SPIRS_DATA_ADDR, 8'h55);
    end_test("slave");
    final_report();
  end
endmodule // spi_rate_and_status_tb
`default_nettype wire
